// ===== design/asc_cfg.svh
// offsets, field positions, command codes and timing counts for the axis stop control block
`ifndef ASC_CFG_SVH
`define ASC_CFG_SVH

// register byte offsets inside one axis window; the axis is chosen by address bit 5
`define ASC_OFF_COMMAND    5'h00
`define ASC_OFF_ENV1       5'h04
`define ASC_OFF_MODE       5'h08
`define ASC_OFF_PRELOAD    5'h0C
`define ASC_OFF_TARGET     5'h10
`define ASC_OFF_STATUS     5'h14
`define ASC_OFF_ERROR      5'h18
`define ASC_AXIS_BIT       5

// environment_config_1 fields
`define ASC_ENV_STOP_METHOD    19
`define ASC_ENV_OVR_POLARITY   24
`define ASC_ENV_OVR_START      30

// operation_mode / operation_mode_preload fields
`define ASC_MODE_COUNT_HOLD    14
`define ASC_MODE_SYNC_LO       18
`define ASC_MODE_SYNC_HI       19
`define ASC_MODE_STOP_ENABLE   24
`define ASC_MODE_AUTO_OUTPUT   25
`define ASC_SYNC_WAIT_START    2'h1

// extension_status fields
`define ASC_STS_STOP_LINE      6
`define ASC_STS_EMERGENCY      7
`define ASC_STS_OVERRIDE       8
`define ASC_CND_IDLE           4'h0
`define ASC_CND_RUN            4'h1
`define ASC_CND_WAIT           4'h2
`define ASC_CND_DECEL          4'h3

// error_cause fields
`define ASC_ERR_AXIS_ERROR     0
`define ASC_ERR_STOP_LINE      8
`define ASC_ERR_EMERGENCY      9

// command codes written to the command register
`define ASC_CMD_EMERGENCY      8'h05
`define ASC_CMD_GROUP_STOP     8'h07
`define ASC_CMD_IMMEDIATE_STOP 8'h49
`define ASC_CMD_START_CONST    8'h50
`define ASC_CMD_START_HIGH     8'h52

// one-shot width on the shared stop line, in reference clock cycles
`define ASC_ONE_SHOT_CYCLES    4'h8
`define ASC_TARGET_BITS        28

`endif

// ===== design/asc_pkg.sv
// types shared by the axis stop control block
package asc_pkg;
  // per-axis operation state
  typedef enum logic [1:0] {
    ASC_IDLE,
    ASC_WAIT,
    ASC_RUN,
    ASC_DECEL
  } asc_state_type;
endpackage

// ===== design/asc_sync2.sv
// two-flop synchroniser for a group of asynchronous pin levels
`timescale 1ns/10ps
`default_nettype none
module asc_sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             sys_clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;   // first stage, read only by the second

  // pins idle high, so both stages reset to ones
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      meta_reg <= '1;
      sync_out <= '1;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule // asc_sync2
`default_nettype wire

// ===== design/asc_one_shot.sv
// fixed-width low pulse driver for the open-drain shared stop line
`timescale 1ns/10ps
`default_nettype none
`include "asc_cfg.svh"
module asc_one_shot (
  input  wire logic sys_clk,
  input  wire logic reset,
  input  wire logic fire,
  output var  logic drive_low
);
  logic [3:0] count_reg;   // cycles left in the pulse

  // a new trigger during a pulse restarts the full width
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      count_reg <= 4'h0;
      drive_low <= 1'b0;
    end else if (fire) begin
      count_reg <= `ASC_ONE_SHOT_CYCLES - 4'h1;
      drive_low <= 1'b1;
    end else if (count_reg != 4'h0) begin
      count_reg <= count_reg - 4'h1;
    end else begin
      drive_low <= 1'b0;
    end
  end
endmodule // asc_one_shot
`default_nettype wire

// ===== design/asc_stop_ctrl.sv
// two-axis start gating, shared stop line and emergency stop control
//
// Contract
// - override input may trigger local axis start
// - start mode 01 waits for shared start
// - override polarity bit 24 selects low/high
// - status bit 8 shows override input
// - stop enable halts axis on stop line
// - decel stop only for high-speed starts
// - stop method bit 19: immediate or decel
// - command 07h drives 8-cycle low pulse
// - error stop with auto bit pulses line
// - stop line is fixed active low
// - each axis stoppable alone by command
// - status bit 6 shows stop line
// - stop line halt sets error bit 8
// - emergency input or command stops all
// - no axis runs while emergency low
// - emergency halt sets error bit 9
// - status bit 7 shows emergency input
// - emergency command equals emergency input
// - counter loads target, may wait override
// - override start only in start mode 01
//
// Decided for this implementation: the plain strobed port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "asc_cfg.svh"
module asc_stop_ctrl
  import asc_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic [5:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output var  logic [31:0] reg_rdata,
  input  wire logic [1:0]  override_input,
  input  wire logic        shared_start_line_in,
  input  wire logic        shared_stop_line_in,
  output var  logic        shared_stop_line_out,
  output var  logic        shared_stop_line_oe,
  input  wire logic        emergency_input,
  input  wire logic [1:0]  feed_pulse,
  input  wire logic [1:0]  axis_error,
  input  wire logic [1:0]  decel_done,
  output var  logic [1:0]  axis_feed_en,
  output var  logic [1:0]  axis_decel_req
);

  // condition code shown in the status register
  function automatic logic [3:0] cond_code(input asc_state_type st);
    unique case (st)
      ASC_IDLE:  cond_code = `ASC_CND_IDLE;
      ASC_WAIT:  cond_code = `ASC_CND_WAIT;
      ASC_RUN:   cond_code = `ASC_CND_RUN;
      ASC_DECEL: cond_code = `ASC_CND_DECEL;
    endcase
  endfunction

  // software registers, one set per axis
  logic [31:0]                 env1_reg      [2];   // environment_config_1
  logic [31:0]                 mode_reg      [2];   // operation_mode in force
  logic [31:0]                 preload_reg   [2];   // operation_mode_preload
  logic [`ASC_TARGET_BITS-1:0] target_reg    [2];   // target_position_reg
  logic [31:0]                 err_reg       [2];   // error_cause, sticky
  // axis state
  asc_state_type               state_reg     [2];
  logic [`ASC_TARGET_BITS-1:0] poscnt_reg    [2];   // positioning counter
  logic                        hispeed_reg   [2];   // started at high speed
  logic                        hold_reg      [2];   // counting held for override

  // synchronised pins
  logic [4:0] pins_sync;                 // {emg, stop, start, ovr[1:0]}
  logic       emg_on;                    // emergency input asserted
  logic       stp_on;                    // shared stop line asserted
  logic       sta_on;                    // shared start line asserted
  logic [1:0] ovr_on;                    // override input asserted per axis
  logic       stop_drive;                // one-shot is pulling the line

  // bus decode
  logic       bus_axis;                  // axis window addressed
  logic [4:0] bus_off;                   // offset inside the window
  logic       cmd_wr;                    // command register written
  logic [7:0] cmd_code;                  // code being written
  logic       emg_cmd;                   // emergency command, all axes
  logic       group_stop_cmd;            // simultaneous stop command
  logic       err_rd_clear [2];          // error_cause read clears it

  // per-axis events
  logic       emg_evt;
  logic       active       [2];          // running or decelerating
  logic       busy         [2];          // active or waiting
  logic       stopcmd      [2];          // own-axis immediate stop
  logic       start_cmd    [2];
  logic       error_stop   [2];
  logic       line_stop    [2];
  logic [31:0] err_set     [2];
  logic       auto_fire;                 // error stop asks for a pulse

  // pins cross into sys_clk before anything looks at them
  asc_sync2 #(
    .WIDTH (5)
  ) u_sync (
    .sys_clk  (sys_clk),
    .reset    (reset),
    .async_in ({emergency_input, shared_stop_line_in, shared_start_line_in, override_input}),
    .sync_out (pins_sync)
  );

  // stop line and emergency input have fixed negative polarity
  always_comb begin
    emg_on = ~pins_sync[4];
    stp_on = ~pins_sync[3];
    sta_on = ~pins_sync[2];
    for (int i = 0; i < 2; i++) begin
      // polarity bit clear means low is on
      ovr_on[i] = ~(pins_sync[i] ^ env1_reg[i][`ASC_ENV_OVR_POLARITY]);
    end
  end

  // address and command decode
  always_comb begin
    bus_axis       = reg_addr[`ASC_AXIS_BIT];
    bus_off        = reg_addr[4:0];
    cmd_wr         = reg_wr && (bus_off == `ASC_OFF_COMMAND);
    cmd_code       = reg_wdata[7:0];
    emg_cmd        = cmd_wr && (cmd_code == `ASC_CMD_EMERGENCY);
    group_stop_cmd = cmd_wr && (cmd_code == `ASC_CMD_GROUP_STOP);
    emg_evt        = emg_on || emg_cmd;
  end

  // stop events per axis, emergency first
  always_comb begin
    auto_fire = 1'b0;
    for (int i = 0; i < 2; i++) begin
      active[i]     = (state_reg[i] == ASC_RUN) || (state_reg[i] == ASC_DECEL);
      busy[i]       = active[i] || (state_reg[i] == ASC_WAIT);
      stopcmd[i]    = cmd_wr && (bus_axis == i[0]) && (cmd_code == `ASC_CMD_IMMEDIATE_STOP);
      start_cmd[i]  = cmd_wr && (bus_axis == i[0])
                      && ((cmd_code == `ASC_CMD_START_CONST) || (cmd_code == `ASC_CMD_START_HIGH));
      error_stop[i] = axis_error[i] && busy[i] && !emg_evt && !stopcmd[i];
      // only an enabled, moving axis listens to the stop line
      line_stop[i]  = stp_on && mode_reg[i][`ASC_MODE_STOP_ENABLE] && active[i]
                      && !emg_evt && !stopcmd[i] && !error_stop[i];
      err_set[i]    = 32'h0000_0000;
      err_set[i][`ASC_ERR_EMERGENCY]  = emg_evt && busy[i];
      err_set[i][`ASC_ERR_STOP_LINE]  = line_stop[i] && (state_reg[i] == ASC_RUN);
      err_set[i][`ASC_ERR_AXIS_ERROR] = error_stop[i];
      if (error_stop[i] && mode_reg[i][`ASC_MODE_AUTO_OUTPUT]) begin
        auto_fire = 1'b1;
      end
    end
  end

  // one pulse generator serves the command and both axes' error stops
  asc_one_shot u_one_shot (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .fire      (group_stop_cmd || auto_fire),
    .drive_low (stop_drive)
  );

  // open-drain drive: pull low during the pulse, release otherwise
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      shared_stop_line_out <= 1'b0;
      shared_stop_line_oe  <= 1'b0;
    end else begin
      shared_stop_line_out <= 1'b0;
      shared_stop_line_oe  <= stop_drive;
    end
  end

  // configuration registers written by software
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      for (int i = 0; i < 2; i++) begin
        env1_reg[i]    <= 32'h0000_0000;
        preload_reg[i] <= 32'h0000_0000;
        target_reg[i]  <= 28'h000_0000;
      end
    end else if (reg_wr) begin
      for (int i = 0; i < 2; i++) begin
        if (bus_axis == i[0]) begin
          if (bus_off == `ASC_OFF_ENV1) begin
            env1_reg[i] <= reg_wdata;
          end
          if (bus_off == `ASC_OFF_PRELOAD) begin
            preload_reg[i] <= reg_wdata;
          end
          if (bus_off == `ASC_OFF_TARGET) begin
            target_reg[i] <= reg_wdata[`ASC_TARGET_BITS-1:0];
          end
        end
      end
    end
  end

  // mode in force: written directly, or taken from the preload at each start
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      for (int i = 0; i < 2; i++) begin
        mode_reg[i] <= 32'h0000_0000;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (reg_wr && (bus_axis == i[0]) && (bus_off == `ASC_OFF_MODE)) begin
          mode_reg[i] <= reg_wdata;
        end else if (start_cmd[i] && (state_reg[i] == ASC_IDLE) && !emg_evt) begin
          mode_reg[i] <= preload_reg[i];
        end
      end
    end
  end

  // axis sequencing: start, wait, feed, stop
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      for (int i = 0; i < 2; i++) begin
        state_reg[i]   <= ASC_IDLE;
        poscnt_reg[i]  <= 28'h000_0000;
        hispeed_reg[i] <= 1'b0;
        hold_reg[i]    <= 1'b0;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (emg_evt) begin
          // every axis, waiting or moving, halts at once
          state_reg[i] <= ASC_IDLE;
        end else if (stopcmd[i] || error_stop[i]) begin
          state_reg[i] <= ASC_IDLE;
        end else if (line_stop[i]) begin
          // a decelerating axis keeps going down until the ramp ends
          if (hispeed_reg[i] && env1_reg[i][`ASC_ENV_STOP_METHOD]) begin
            state_reg[i] <= ASC_DECEL;
          end else begin
            state_reg[i] <= ASC_IDLE;
          end
        end else begin
          unique case (state_reg[i])
            ASC_IDLE: begin
              // starts are refused while the emergency input is on
              if (start_cmd[i] && !emg_on) begin
                poscnt_reg[i]  <= target_reg[i];
                hispeed_reg[i] <= (cmd_code == `ASC_CMD_START_HIGH);
                hold_reg[i]    <= preload_reg[i][`ASC_MODE_COUNT_HOLD];
                if (preload_reg[i][`ASC_MODE_SYNC_HI:`ASC_MODE_SYNC_LO] == `ASC_SYNC_WAIT_START) begin
                  state_reg[i] <= ASC_WAIT;
                end else begin
                  state_reg[i] <= ASC_RUN;
                end
              end
            end
            ASC_WAIT: begin
              // the override input starts this axis only, never the shared line
              if (sta_on || (env1_reg[i][`ASC_ENV_OVR_START] && ovr_on[i])) begin
                state_reg[i] <= ASC_RUN;
              end
            end
            ASC_RUN, ASC_DECEL: begin
              if (ovr_on[i]) begin
                hold_reg[i] <= 1'b0;
              end
              if (poscnt_reg[i] == 28'h000_0000) begin
                state_reg[i] <= ASC_IDLE;
              end else if ((state_reg[i] == ASC_DECEL) && decel_done[i]) begin
                state_reg[i] <= ASC_IDLE;
              end else if (feed_pulse[i] && !hold_reg[i]) begin
                // reaching zero ends the move on the next edge
                poscnt_reg[i] <= poscnt_reg[i] - 28'h000_0001;
              end
            end
          endcase
        end
      end
    end
  end

  // error causes: sticky, cleared by reading; a new event beats the clear
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      err_rd_clear[i] = reg_rd && (bus_axis == i[0]) && (bus_off == `ASC_OFF_ERROR);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      for (int i = 0; i < 2; i++) begin
        err_reg[i] <= 32'h0000_0000;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        err_reg[i] <= (err_rd_clear[i] ? 32'h0000_0000 : err_reg[i]) | err_set[i];
      end
    end
  end

  // drive outputs from flops, one cycle behind the axis state
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      axis_feed_en   <= 2'b00;
      axis_decel_req <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        axis_feed_en[i]   <= active[i];
        axis_decel_req[i] <= (state_reg[i] == ASC_DECEL);
      end
    end
  end

  // read data appear in the cycle after the strobe; write-only and unmapped read zero
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= 32'h0000_0000;
      if (reg_rd) begin
        unique case (bus_off)
          `ASC_OFF_STATUS: begin
            reg_rdata[3:0]                  <= cond_code(state_reg[bus_axis]);
            reg_rdata[`ASC_STS_STOP_LINE]   <= stp_on;
            reg_rdata[`ASC_STS_EMERGENCY]   <= emg_on;
            reg_rdata[`ASC_STS_OVERRIDE]    <= ovr_on[bus_axis];
          end
          `ASC_OFF_ERROR: begin
            reg_rdata <= err_reg[bus_axis];
          end
          `ASC_OFF_TARGET: begin
            // remaining count, not the target written
            reg_rdata[`ASC_TARGET_BITS-1:0] <= poscnt_reg[bus_axis];
          end
          default: begin
            reg_rdata <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

endmodule // asc_stop_ctrl
`default_nettype wire

// ===== sim/asc_stop_ctrl_monitor.sv
// port checks for the axis stop control block
`timescale 1ns/10ps
`default_nettype none
`include "asc_cfg.svh"
module asc_stop_ctrl_monitor (
  input wire logic        sys_clk,
  input wire logic        reset,
  input wire logic [5:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        shared_stop_line_in,
  input wire logic        shared_stop_line_out,
  input wire logic        shared_stop_line_oe,
  input wire logic        emergency_input,
  input wire logic [1:0]  axis_error,
  input wire logic [1:0]  axis_feed_en
);
  logic       grp_wr;     // group stop command written
  logic       emg_wr;     // emergency command written
  logic [5:0] cause_reg;  // recent reasons for a pulse
  logic       en_reg;     // axis 0 line stop enable
  logic       dec_reg;    // axis 0 decel method
  assign grp_wr = reg_wr && reg_addr[4:0] == `ASC_OFF_COMMAND && reg_wdata[7:0] == `ASC_CMD_GROUP_STOP;
  assign emg_wr = reg_wr && reg_addr[4:0] == `ASC_OFF_COMMAND && reg_wdata[7:0] == `ASC_CMD_EMERGENCY;
  // recent causes a pulse may follow
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cause_reg <= 6'h00;
    end else begin
      cause_reg <= {cause_reg[4:0], grp_wr | (|axis_error)};
    end
  end
  // axis 0 settings shadow, written before each start
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      en_reg  <= 1'b0;
      dec_reg <= 1'b0;
    end else if (reg_wr && reg_addr == {1'b0, `ASC_OFF_PRELOAD}) begin
      en_reg <= reg_wdata[`ASC_MODE_STOP_ENABLE];
    end else if (reg_wr && reg_addr == {1'b0, `ASC_OFF_ENV1}) begin
      dec_reg <= reg_wdata[`ASC_ENV_STOP_METHOD];
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  chk_pulse_width: assert property ($rose(shared_stop_line_oe) |-> shared_stop_line_oe[*8])
    else $error("short pulse");
  chk_cmd_pulse: assert property (grp_wr |-> ##2 shared_stop_line_oe)
    else $error("no pulse");
  chk_only_low: assert property (shared_stop_line_oe |-> !shared_stop_line_out)
    else $error("driven high");
  chk_pulse_cause: assert property ($rose(shared_stop_line_oe) |-> |cause_reg)
    else $error("pulse without cause");
  chk_line_halt: assert property ((!shared_stop_line_in && en_reg && !dec_reg)[*6] |-> !axis_feed_en[0])
    else $error("no line halt");
  chk_emg_block: assert property ((!emergency_input)[*6] |-> axis_feed_en == 2'b00)
    else $error("runs in emergency");
  chk_emg_cmd: assert property (emg_wr |-> ##[1:3] axis_feed_en == 2'b00)
    else $error("no emergency halt");
  chk_read_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
    else $error("stray read data");
  cov_group: cover property (grp_wr ##2 shared_stop_line_oe);
  cov_emg: cover property ($fell(emergency_input));
  cov_error: cover property (|axis_error ##[1:8] shared_stop_line_oe);
endmodule // asc_stop_ctrl_monitor
bind asc_stop_ctrl asc_stop_ctrl_monitor u_mon (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .shared_stop_line_in(shared_stop_line_in), .shared_stop_line_out(shared_stop_line_out),
  .shared_stop_line_oe(shared_stop_line_oe), .emergency_input(emergency_input),
  .axis_error(axis_error), .axis_feed_en(axis_feed_en));
`default_nettype wire

// ===== sim/asc_line_partner.sv
// far side: open-collector drivers on the shared lines
`timescale 1ns/10ps
`default_nettype none
module asc_line_partner #(
  parameter int PULSE_CYCLES = 4  // external pulse width
) (
  input  wire logic sys_clk,
  input  wire logic dut_out,
  input  wire logic dut_oe,
  input  wire logic stop_fire,
  input  wire logic start_fire,
  output var  logic stop_line,
  output var  logic start_line
);
  logic [3:0] stop_cnt_reg  = 4'h0;  // low cycles left on the stop line
  logic [3:0] start_cnt_reg = 4'h0;  // low cycles left on the start line
  // a request reloads the full width, so no pulse is shorter than the minimum
  always_ff @(posedge sys_clk) begin
    stop_cnt_reg  <= stop_fire ? 4'(PULSE_CYCLES) : stop_cnt_reg - 4'(stop_cnt_reg != 4'h0);
    start_cnt_reg <= start_fire ? 4'(PULSE_CYCLES) : start_cnt_reg - 4'(start_cnt_reg != 4'h0);
  end
  // wired-and with pull-up: released lines read high
  assign stop_line  = !((dut_oe && !dut_out) || stop_cnt_reg != 4'h0);
  assign start_line = start_cnt_reg == 4'h0;
endmodule // asc_line_partner
`default_nettype wire

// ===== sim/test_axis_stop_control.sv
// bench for the axis stop control block
`timescale 1ns/10ps
`default_nettype none
`include "asc_cfg.svh"
module test_axis_stop_control;
  logic        sys_clk    = 1'b0;
  logic        reset      = 1'b1;
  logic [5:0]  reg_addr   = 6'h00;
  logic [31:0] reg_wdata  = 32'h0000_0000;
  logic        reg_wr     = 1'b0;
  logic        reg_rd     = 1'b0;
  logic [31:0] reg_rdata;
  logic [1:0]  ovr        = 2'b11;  // high is off at reset polarity
  logic        emg        = 1'b1;   // emergency pin, low is on
  logic [1:0]  feed       = 2'b00;
  logic [1:0]  err_in     = 2'b00;
  logic [1:0]  done       = 2'b00;
  logic        stop_fire  = 1'b0;
  logic        start_fire = 1'b0;
  logic        stop_line;
  logic        start_line;
  logic        stop_out;
  logic        stop_oe;
  logic [1:0]  feed_en;
  logic [1:0]  decel_req;
  int          err_count  = 0;
  int          n_compared = 0;
  int          cycles     = 0;
  always #20 sys_clk = ~sys_clk;
  asc_stop_ctrl u_dut (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .override_input(ovr),
    .shared_start_line_in(start_line), .shared_stop_line_in(stop_line), .shared_stop_line_out(stop_out),
    .shared_stop_line_oe(stop_oe), .emergency_input(emg), .feed_pulse(feed), .axis_error(err_in),
    .decel_done(done), .axis_feed_en(feed_en), .axis_decel_req(decel_req));
  asc_line_partner u_far (.sys_clk(sys_clk), .dut_out(stop_out), .dut_oe(stop_oe), .stop_fire(stop_fire),
    .start_fire(start_fire), .stop_line(stop_line), .start_line(start_line));
  function automatic logic [5:0] ad(input logic ax, input logic [4:0] off);
    return {ax, off};
  endfunction
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic [1:0] got, input logic [1:0] exp);
    chk_reg({30'h0, got}, {30'h0, exp});
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  // masked read, data one cycle after strobe
  task automatic rd(input logic [5:0] a, input logic [31:0] m, input logic [31:0] exp);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk_reg(reg_rdata & m, exp);
  endtask
  task automatic cmd(input logic ax, input logic [7:0] c);
    wr(ad(ax, `ASC_OFF_COMMAND), {24'h00_0000, c});
  endtask
  task automatic go(input logic ax, input logic [31:0] pre, input logic [31:0] tgt, input logic [7:0] c);
    wr(ad(ax, `ASC_OFF_PRELOAD), pre);
    wr(ad(ax, `ASC_OFF_TARGET), tgt);
    cmd(ax, c);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic step(input logic ax);
    @(posedge sys_clk);
    feed <= ax ? 2'b10 : 2'b01;
    @(posedge sys_clk);
    feed <= 2'b00;
  endtask
  task automatic print_verdict();
    $display("errors %0d compared %0d", err_count, n_compared);
    if (err_count == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // hang guard
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      err_count++;
      print_verdict();
    end
  end
  initial begin
    repeat (8) @(posedge sys_clk);
    reset <= 1'b0;
    // reset state; unmapped reads zero
    rd(ad(1'b0, `ASC_OFF_STATUS), 32'h0000_01CF, 32'h0000_0000);
    rd(ad(1'b0, `ASC_OFF_ERROR), 32'hFFFF_FFFF, 32'h0000_0000);
    rd(6'h1C, 32'hFFFF_FFFF, 32'h0000_0000);
    rd(ad(1'b1, `ASC_OFF_ENV1), 32'hFFFF_FFFF, 32'h0000_0000);
    // override polarity
    @(posedge sys_clk);
    ovr <= 2'b10;
    cyc(3);
    rd(ad(1'b0, `ASC_OFF_STATUS), 32'h0000_0100, 32'h0000_0100);
    wr(ad(1'b0, `ASC_OFF_ENV1), 32'h0100_0000);
    rd(ad(1'b0, `ASC_OFF_STATUS), 32'h0000_0100, 32'h0000_0000);
    ovr <= 2'b11;
    // override frees axis 0, start line axis 1
    wr(ad(1'b0, `ASC_OFF_ENV1), 32'h4000_0000);
    go(1'b0, 32'h0004_0000, 32'h0000_0005, `ASC_CMD_START_CONST);
    go(1'b1, 32'h0004_0000, 32'h0000_0005, `ASC_CMD_START_CONST);
    rd(ad(1'b1, `ASC_OFF_STATUS), 32'h0000_000F, {28'h000_0000, `ASC_CND_WAIT});
    ovr <= 2'b10;
    cyc(5);
    chk_pin(feed_en, 2'b01);
    start_fire <= 1'b1;
    @(posedge sys_clk);
    start_fire <= 1'b0;
    cyc(6);
    chk_pin(feed_en, 2'b11);
    cmd(1'b0, `ASC_CMD_IMMEDIATE_STOP);
    cmd(1'b1, `ASC_CMD_IMMEDIATE_STOP);
    ovr <= 2'b11;
    wr(ad(1'b0, `ASC_OFF_ENV1), 32'h0000_0000);
    // counter, then hold until override
    go(1'b0, 32'h0000_0000, 32'h0000_0003, `ASC_CMD_START_CONST);
    step(1'b0);
    step(1'b0);
    rd(ad(1'b0, `ASC_OFF_TARGET), 32'h0FFF_FFFF, 32'h0000_0001);
    step(1'b0);
    cyc(3);
    chk_pin(feed_en, 2'b00);
    go(1'b0, 32'h0000_4000, 32'h0000_0003, `ASC_CMD_START_CONST);
    step(1'b0);
    rd(ad(1'b0, `ASC_OFF_TARGET), 32'h0FFF_FFFF, 32'h0000_0003);
    ovr <= 2'b10;
    cyc(3);
    step(1'b0);
    rd(ad(1'b0, `ASC_OFF_TARGET), 32'h0FFF_FFFF, 32'h0000_0002);
    cmd(1'b0, `ASC_CMD_IMMEDIATE_STOP);
    ovr <= 2'b11;
    // group stop halts the enabled axis only
    go(1'b0, 32'h0100_0000, 32'h0000_0064, `ASC_CMD_START_CONST);
    go(1'b1, 32'h0000_0000, 32'h0000_0064, `ASC_CMD_START_CONST);
    cmd(1'b0, `ASC_CMD_GROUP_STOP);
    #1 chk_pin({stop_out, stop_oe}, 2'b00);
    cyc(1);
    chk_pin({stop_out, stop_oe}, 2'b01);
    cyc(7);
    chk_pin({stop_out, stop_oe}, 2'b01);
    cyc(1);
    chk_pin({stop_out, stop_oe}, 2'b00);
    chk_pin(feed_en, 2'b10);
    rd(ad(1'b0, `ASC_OFF_ERROR), 32'hFFFF_FFFF, 32'h0000_0100);
    rd(ad(1'b0, `ASC_OFF_ERROR), 32'hFFFF_FFFF, 32'h0000_0000);
    cmd(1'b1, `ASC_CMD_IMMEDIATE_STOP);
    cyc(2);
    chk_pin(feed_en, 2'b00);
    stop_fire <= 1'b1;
    cyc(3);
    rd(ad(1'b0, `ASC_OFF_STATUS), 32'h0000_0040, 32'h0000_0040);
    stop_fire <= 1'b0;
    // decel method: high-speed ramps, constant stops
    wr(ad(1'b0, `ASC_OFF_ENV1), 32'h0008_0000);
    for (int i = 0; i < 2; i++) begin
      go(1'b0, 32'h0100_0000, 32'h0000_0064, i ? `ASC_CMD_START_CONST : `ASC_CMD_START_HIGH);
      stop_fire <= 1'b1;
      @(posedge sys_clk);
      stop_fire <= 1'b0;
      cyc(8);
      chk_pin(decel_req, i ? 2'b00 : 2'b01);
      chk_pin(feed_en, i ? 2'b00 : 2'b01);
      done <= 2'b01;
      @(posedge sys_clk);
      done <= 2'b00;
      cyc(3);
      chk_pin(feed_en, 2'b00);
      rd(ad(1'b0, `ASC_OFF_ERROR), 32'h0000_0100, 32'h0000_0100);
    end
    wr(ad(1'b0, `ASC_OFF_ENV1), 32'h0000_0000);
    // auto pulse on error stop
    go(1'b1, 32'h0200_0000, 32'h0000_0064, `ASC_CMD_START_CONST);
    err_in <= 2'b10;
    cyc(3);
    chk_pin({stop_out, stop_oe}, 2'b01);
    err_in <= 2'b00;
    rd(ad(1'b1, `ASC_OFF_ERROR), 32'h0000_0001, 32'h0000_0001);
    // emergency pin, then command
    go(1'b0, 32'h0000_0000, 32'h0000_0064, `ASC_CMD_START_CONST);
    go(1'b1, 32'h0000_0000, 32'h0000_0064, `ASC_CMD_START_CONST);
    emg <= 1'b0;
    cyc(6);
    chk_pin(feed_en, 2'b00);
    rd(ad(1'b0, `ASC_OFF_STATUS), 32'h0000_0080, 32'h0000_0080);
    rd(ad(1'b0, `ASC_OFF_ERROR), 32'h0000_0200, 32'h0000_0200);
    cmd(1'b0, `ASC_CMD_START_CONST);
    cyc(3);
    chk_pin(feed_en, 2'b00);
    emg <= 1'b1;
    cyc(4);
    cmd(1'b0, `ASC_CMD_START_CONST);
    cmd(1'b1, `ASC_CMD_START_CONST);
    cyc(2);
    chk_pin(feed_en, 2'b11);
    cmd(1'b0, `ASC_CMD_EMERGENCY);
    cyc(3);
    chk_pin(feed_en, 2'b00);
    rd(ad(1'b0, `ASC_OFF_ERROR), 32'h0000_0200, 32'h0000_0200);
    print_verdict();
  end
endmodule // test_axis_stop_control
`default_nettype wire
